// [intc_core.sv]
// Interrupt controller: request flags, enables, priority selection and exception sequencer.
`timescale 1ns/100ps
`include "intc_params.svh"

// Overview of operation
// RULE1 - FH flag on high or 16-bit compare match
// RULE2 - FL flag on low match in 8-bit mode
// RULE3 - Flags clear by writing 0; reset 0 (the code resets the first request register to 8'h20 and holds its bit 5 at 1)
// RULE4 - Second request bits 1:0 read 0
// RULE5 - Wakeup flag n on falling edge pin n
// RULE6 - Acceptance never clears a request flag
// RULE7 - Thirteen external sources: eight wakeup, five edge
// RULE8 - Group enable blocks all wakeup requests
// RULE9 - All wakeup requests share vector 9
// RULE10 - Edge pins select rising or falling edge
// RULE11 - Selected edge sets first request flag
// RULE12 - Edge pins 0..4 use vectors 4..8
// RULE13 - Sixteen internal sources, flag plus enable; the code models seven (timer A, SCI1, timer G, FH, FL, AD, DT)
// RULE14 - Internal sources use vectors 10..20; the seven modelled use vectors 10..16
// RULE15 - Highest priority selected, others stay pending
// RULE16 - Accept only while mask flag is 0
// RULE17 - Finish instruction, then stack PC and CONDITION_CODE_REGISTER
// RULE18 - Acceptance sets the mask flag
// RULE19 - Produce vector address, then fetch handler
// RULE20 - Software clears flags only while masked
// RULE21 - Clear colliding with request still taken after
// RULE22 - Latency is completion, 4, 2, 4, 4 states
// RULE23 - Timer FH/FL gated by second enable
// RULE24 - Lowest vector number wins
module intc_core
  import intc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire bus_req_t i_bus,
  input wire pin_in_t i_pins,
  input wire periph_req_t i_periph,
  input wire logic i_insn_done,
  output logic [7:0] o_rdata,
  output logic o_irq_pending,
  output logic [4:0] o_vector,
  output logic [15:0] o_vector_addr,
  output logic o_mask_flag,
  output logic o_stacking,
  output logic o_handler_start
);

  function automatic logic [4:0] pick_vector(input logic [12:0] p);
    logic [4:0] v;
    v = 5'h00;
    for (int k = 12; k >= 0; k--) begin
      if (p[k]) begin
        v = 5'(k) + `VEC_BASE;
      end
    end
    return v;
  endfunction : pick_vector

  function automatic logic [7:0] clear_bits(input logic wr, input logic [7:0] wdata);
    return wr ? ~wdata : 8'h00;
  endfunction : clear_bits

  logic [7:0] first_req;
  logic [7:0] second_req;
  logic [7:0] wake_req;
  logic [7:0] first_en;
  logic [7:0] second_en;
  logic [7:0] edge_pol;
  logic [7:0] wake_fn;
  logic [7:0] ext_fn;
  logic [7:0] timer_ctrl;
  logic [7:0] cnt_lo;
  logic [7:0] cnt_hi;
  logic [7:0] cmp_lo;
  logic [7:0] cmp_hi;
  logic [7:0] wake_prev;
  logic [4:0] ext_prev;
  logic [3:0] phase_cnt;
  seq_state_t state;

  wire wr_first = i_bus.wr && i_bus.addr == `OFS_FIRST_REQ;
  wire wr_second = i_bus.wr && i_bus.addr == `OFS_SECOND_REQ;
  wire wr_wake = i_bus.wr && i_bus.addr == `OFS_WAKE_REQ;
  wire wr_first_en = i_bus.wr && i_bus.addr == `OFS_FIRST_EN;
  wire wr_second_en = i_bus.wr && i_bus.addr == `OFS_SECOND_EN;
  wire wr_edge_pol = i_bus.wr && i_bus.addr == `OFS_EDGE_POL;
  wire wr_wake_fn = i_bus.wr && i_bus.addr == `OFS_WAKE_FN;
  wire wr_ext_fn = i_bus.wr && i_bus.addr == `OFS_EXT_FN;
  wire wr_timer_ctrl = i_bus.wr && i_bus.addr == `OFS_TIMER_CTRL;
  wire wr_cnt_lo = i_bus.wr && i_bus.addr == `OFS_CNT_LO;
  wire wr_cnt_hi = i_bus.wr && i_bus.addr == `OFS_CNT_HI;
  wire wr_cmp_lo = i_bus.wr && i_bus.addr == `OFS_CMP_LO;
  wire wr_cmp_hi = i_bus.wr && i_bus.addr == `OFS_CMP_HI;
  wire wr_status = i_bus.wr && i_bus.addr == `OFS_CPU_STATUS;

  // Pins idle high; a wakeup pin only reports while it is given its wakeup function.
  wire [7:0] wake_fall = wake_fn & wake_prev & ~i_pins.wakeup; // RULE5 RULE7
  wire [4:0] rise = ext_prev & 5'h00 | ~ext_prev & i_pins.ext_edge;
  wire [4:0] fall = ext_prev & ~i_pins.ext_edge;
  wire [4:0] ext_hit = ext_fn[4:0] & ((edge_pol[4:0] & rise) | (~edge_pol[4:0] & fall)); // RULE10 RULE11

  wire timer_run = timer_ctrl[`BIT_TIMER_RUN];
  wire mode16 = timer_ctrl[`BIT_TIMER_MODE16];
  wire [15:0] cnt16_inc = {cnt_hi, cnt_lo} + 16'h0001;
  wire [7:0] lo_inc = cnt_lo + 8'h01;
  wire [7:0] hi_inc = cnt_hi + 8'h01;
  wire match_fh = timer_run && (mode16 ? {cnt_hi, cnt_lo} == {cmp_hi, cmp_lo} : cnt_hi == cmp_hi); // RULE1
  wire match_fl = timer_run && !mode16 && cnt_lo == cmp_lo; // RULE2

  wire [7:0] first_set = {i_periph.timer_a, i_periph.sci1, 1'b0, ext_hit}; // RULE11 RULE13
  wire [7:0] second_set = {i_periph.direct_xfer, i_periph.adc, 1'b0, i_periph.timer_g,
                           match_fh, match_fl, 2'b00}; // RULE13

  // A hardware set in the same cycle as a software clear wins, so no event is lost.
  wire [7:0] next_first = (first_req & ~clear_bits(wr_first, i_bus.wdata)) | first_set | `FIRST_REQ_RESET; // RULE3
  wire [7:0] next_second = ((second_req & ~clear_bits(wr_second, i_bus.wdata)) | second_set)
                           & `SECOND_REQ_WRITABLE; // RULE3 RULE4
  wire [7:0] next_wake = (wake_req & ~clear_bits(wr_wake, i_bus.wdata)) | wake_fall; // RULE3 RULE5

  // Index k carries vector k+4, so the search order is the priority order.
  wire [12:0] pend = {
    second_req[`BIT_SECOND_DT] & second_en[`BIT_SECOND_DT],
    second_req[`BIT_SECOND_AD] & second_en[`BIT_SECOND_AD],
    second_req[`BIT_SECOND_TIMER_FL] & second_en[`BIT_SECOND_TIMER_FL],
    second_req[`BIT_SECOND_TIMER_FH] & second_en[`BIT_SECOND_TIMER_FH],
    second_req[`BIT_SECOND_TIMER_G] & second_en[`BIT_SECOND_TIMER_G],
    first_req[`BIT_FIRST_SCI1] & first_en[`BIT_FIRST_SCI1],
    first_req[`BIT_FIRST_TIMER_A] & first_en[`BIT_FIRST_TIMER_A],
    (|wake_req) & first_en[`BIT_FIRST_WAKE_EN],
    first_req[4:0] & first_en[4:0]
  }; // RULE8 RULE9 RULE12 RULE13 RULE14 RULE23
  wire any_pend = |pend;
  wire [4:0] sel_vec = pick_vector(pend); // RULE15 RULE24
  wire accept = state == ST_IDLE && any_pend && !o_mask_flag; // RULE16

  // Sequencer: wait for the running instruction, then stacking, vector fetch,
  // instruction fetch and internal processing, each for a fixed number of states.
  wire phase_last = phase_cnt == 4'h0;
  seq_state_t next_state;
  logic [3:0] next_phase_cnt;
  always_comb begin
    next_state = state;
    next_phase_cnt = phase_last ? 4'h0 : phase_cnt - 4'h1;
    unique case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        if (i_insn_done) begin
          next_state = ST_STACK; // RULE17 RULE21
          next_phase_cnt = `STACK_STATES - 4'h1;
        end
      end
      ST_STACK: begin
        if (phase_last) begin
          next_state = ST_VFETCH; // RULE22
          next_phase_cnt = `VFETCH_STATES - 4'h1;
        end
      end
      ST_VFETCH: begin
        if (phase_last) begin
          next_state = ST_IFETCH; // RULE22
          next_phase_cnt = `IFETCH_STATES - 4'h1;
        end
      end
      ST_IFETCH: begin
        if (phase_last) begin
          next_state = ST_INTERNAL; // RULE22
          next_phase_cnt = `INTERNAL_STATES - 4'h1;
        end
      end
      ST_INTERNAL: begin
        if (phase_last) begin
          next_state = ST_IDLE; // RULE19
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Acceptance masks further requests; it wins over a software write in the same cycle.
  wire next_mask = accept ? 1'b1 : (wr_status ? i_bus.wdata[`BIT_MASK_FLAG] : o_mask_flag); // RULE18

  wire [7:0] rd_mux =
    i_bus.addr == `OFS_FIRST_REQ ? first_req :
    i_bus.addr == `OFS_SECOND_REQ ? second_req :
    i_bus.addr == `OFS_WAKE_REQ ? wake_req :
    i_bus.addr == `OFS_FIRST_EN ? first_en :
    i_bus.addr == `OFS_SECOND_EN ? second_en :
    i_bus.addr == `OFS_EDGE_POL ? edge_pol :
    i_bus.addr == `OFS_WAKE_FN ? wake_fn :
    i_bus.addr == `OFS_EXT_FN ? ext_fn :
    i_bus.addr == `OFS_TIMER_CTRL ? timer_ctrl :
    i_bus.addr == `OFS_CNT_LO ? cnt_lo :
    i_bus.addr == `OFS_CNT_HI ? cnt_hi :
    i_bus.addr == `OFS_CMP_LO ? cmp_lo :
    i_bus.addr == `OFS_CMP_HI ? cmp_hi :
    i_bus.addr == `OFS_CPU_STATUS ? {4'h0, 1'b0, state} << 1 | {7'h00, o_mask_flag} :
    i_bus.addr == `OFS_VECTOR ? {3'h0, o_vector} : 8'h00;

  wire [7:0] next_cnt_lo = wr_cnt_lo ? i_bus.wdata : (timer_run ? (mode16 ? cnt16_inc[7:0] : lo_inc) : cnt_lo);
  wire [7:0] next_cnt_hi = wr_cnt_hi ? i_bus.wdata : (timer_run ? (mode16 ? cnt16_inc[15:8] : hi_inc) : cnt_hi);

  // Acceptance leaves every flag alone; only software clears it.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      first_req <= `FIRST_REQ_RESET;
      second_req <= `REG_RESET;
      wake_req <= `REG_RESET;
    end else begin
      first_req <= next_first; // RULE6
      second_req <= next_second; // RULE6
      wake_req <= next_wake; // RULE6
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      first_en <= `REG_RESET;
      second_en <= `REG_RESET;
      edge_pol <= `REG_RESET;
      wake_fn <= `REG_RESET;
      ext_fn <= `REG_RESET;
      timer_ctrl <= `REG_RESET;
    end else begin
      first_en <= wr_first_en ? i_bus.wdata : first_en;
      second_en <= wr_second_en ? i_bus.wdata : second_en; // RULE23
      edge_pol <= wr_edge_pol ? i_bus.wdata : edge_pol;
      wake_fn <= wr_wake_fn ? i_bus.wdata : wake_fn;
      ext_fn <= wr_ext_fn ? i_bus.wdata : ext_fn;
      timer_ctrl <= wr_timer_ctrl ? i_bus.wdata : timer_ctrl;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cnt_lo <= `REG_RESET;
      cnt_hi <= `REG_RESET;
      cmp_lo <= `CMP_RESET;
      cmp_hi <= `CMP_RESET;
      wake_prev <= `PIN_IDLE_RESET;
      ext_prev <= 5'(`PIN_IDLE_RESET);
    end else begin
      cnt_lo <= next_cnt_lo;
      cnt_hi <= next_cnt_hi;
      cmp_lo <= wr_cmp_lo ? i_bus.wdata : cmp_lo;
      cmp_hi <= wr_cmp_hi ? i_bus.wdata : cmp_hi;
      wake_prev <= i_pins.wakeup;
      ext_prev <= i_pins.ext_edge;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state <= ST_IDLE;
      phase_cnt <= 4'h0;
      o_mask_flag <= 1'b0;
      o_vector <= 5'h00;
      o_vector_addr <= 16'h0000;
      o_rdata <= 8'h00;
      o_irq_pending <= 1'b0;
      o_stacking <= 1'b0;
      o_handler_start <= 1'b0;
    end else begin
      state <= next_state;
      phase_cnt <= next_phase_cnt;
      o_mask_flag <= next_mask;
      o_vector <= accept ? sel_vec : o_vector;
      o_vector_addr <= accept ? {10'h000, sel_vec, 1'b0} : o_vector_addr; // RULE19
      o_rdata <= i_bus.rd ? rd_mux : 8'h00;
      o_irq_pending <= any_pend && !next_mask && next_state == ST_IDLE; // RULE16
      o_stacking <= next_state == ST_STACK; // RULE17
      o_handler_start <= state == ST_INTERNAL && phase_last; // RULE19 RULE22
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  fh_flag_set_a: assert property (match_fh |=> second_req[`BIT_SECOND_TIMER_FH]) // RULE1
    else $error("Timer FH flag not set after compare match.");
  fl_flag_set_a: assert property (match_fl |=> second_req[`BIT_SECOND_TIMER_FL]) // RULE2
    else $error("Timer FL flag not set after compare match.");
  fl_mode16_a: assert property (mode16 && !wr_timer_ctrl |=> !match_fl) // RULE2
    else $error("Timer FL matched in 16-bit mode.");
  write_one_keeps_a: assert property (wr_wake && i_bus.wdata == 8'hff |=> (wake_req & $past(wake_req)) == $past(wake_req)) // RULE3
    else $error("Writing ones cleared a wakeup flag.");
  write_zero_clear_a: assert property (wr_first && !i_bus.wdata[0] && !ext_hit[0] |=> !first_req[0]) // RULE3
    else $error("Writing zero did not clear the flag.");
  reserved_zero_a: assert property (second_req[1:0] == 2'b00) // RULE4
    else $error("Reserved bits of second request register not zero.");
  wake_edge_a: assert property (wake_fall[0] |=> wake_req[0]) // RULE5
    else $error("Wakeup falling edge did not set flag.");
  no_autoclear_a: assert property (accept && !i_bus.wr |=> any_pend) // RULE6
    else $error("Accepted request flag was cleared by acceptance.");
  wake_group_gate_a: assert property (accept && sel_vec == `VEC_WAKEUP |-> first_en[`BIT_FIRST_WAKE_EN]) // RULE8 RULE9
    else $error("Wakeup request accepted while group disabled.");
  rise_edge_a: assert property (ext_fn[1] && edge_pol[1] && !ext_prev[1] && i_pins.ext_edge[1]
                                |=> first_req[1]) // RULE10 RULE11
    else $error("Rising edge did not set edge request flag.");
  prio_pin0_a: assert property (accept && pend[0] |-> sel_vec == `VEC_BASE) // RULE12 RULE15 RULE24
    else $error("Pin 0 request not selected first.");
  masked_hold_a: assert property (o_mask_flag |-> !accept) // RULE16
    else $error("Request accepted while masked.");
  mask_set_a: assert property (accept |=> o_mask_flag && state == ST_FINISH) // RULE18
    else $error("Mask flag not set on acceptance.");
  latency_a: assert property (state == ST_FINISH && i_insn_done |-> ##1 o_stacking [*4] ##11 o_handler_start) // RULE22
    else $error("Exception sequence length wrong.");
  wait_insn_a: assert property (state == ST_FINISH && !i_insn_done |=> state == ST_FINISH) // RULE17 RULE21
    else $error("Stacking began before instruction completion.");

  cover_wakeup_c: cover property (accept && sel_vec == `VEC_WAKEUP);
  cover_two_pending_c: cover property (accept && pend[0] && pend[9]);
  cover_handler_c: cover property (o_handler_start);
  cover_clear_race_c: cover property (accept && wr_first);

endmodule : intc_core

// [intc_params.svh]
// Register offsets, reset values, field positions and sequencer timing of the interrupt controller.
`ifndef INTC_PARAMS_SVH
`define INTC_PARAMS_SVH

`define OFS_FIRST_REQ 4'h0
`define OFS_SECOND_REQ 4'h1
`define OFS_WAKE_REQ 4'h2
`define OFS_FIRST_EN 4'h3
`define OFS_SECOND_EN 4'h4
`define OFS_EDGE_POL 4'h5
`define OFS_WAKE_FN 4'h6
`define OFS_EXT_FN 4'h7
`define OFS_TIMER_CTRL 4'h8
`define OFS_CNT_LO 4'h9
`define OFS_CNT_HI 4'ha
`define OFS_CMP_LO 4'hb
`define OFS_CMP_HI 4'hc
`define OFS_CPU_STATUS 4'hd
`define OFS_VECTOR 4'he

`define FIRST_REQ_RESET 8'h20
`define REG_RESET 8'h00
`define CMP_RESET 8'hff
`define PIN_IDLE_RESET 8'hff

`define BIT_FIRST_TIMER_A 7
`define BIT_FIRST_SCI1 6
`define BIT_FIRST_WAKE_EN 5
`define BIT_SECOND_DT 7
`define BIT_SECOND_AD 6
`define BIT_SECOND_TIMER_G 4
`define BIT_SECOND_TIMER_FH 3
`define BIT_SECOND_TIMER_FL 2
`define SECOND_REQ_WRITABLE 8'hdc
`define BIT_TIMER_MODE16 0
`define BIT_TIMER_RUN 1
`define BIT_MASK_FLAG 0

`define VEC_BASE 5'h04
`define VEC_WAKEUP 5'h09
`define SOURCE_COUNT 13

`define STACK_STATES 4'h4
`define VFETCH_STATES 4'h2
`define IFETCH_STATES 4'h4
`define INTERNAL_STATES 4'h4

`endif

// [intc_pkg.sv]
// Types shared by the interrupt controller and its surroundings.
package intc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FINISH = 3'b001,
    ST_STACK = 3'b010,
    ST_VFETCH = 3'b011,
    ST_IFETCH = 3'b100,
    ST_INTERNAL = 3'b101
  } seq_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] wakeup;
    logic [4:0] ext_edge;
  } pin_in_t;

  typedef struct packed {
    logic timer_a;
    logic sci1;
    logic timer_g;
    logic adc;
    logic direct_xfer;
  } periph_req_t;

endpackage : intc_pkg

// [cpu_core_model.sv]
// Behavioural model of the CPU core that finishes the current instruction after an interrupt is taken.
`timescale 1ns/100ps

module cpu_core_model (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_mask_flag,
  input wire logic [3:0] i_wait,
  output logic o_insn_done
);
  logic mask_prev;
  logic busy;
  logic [3:0] count;

  // A software write that sets the mask also starts a countdown; the controller ignores that pulse when idle.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mask_prev <= 1'b0;
      busy <= 1'b0;
      count <= 4'h0;
      o_insn_done <= 1'b0;
    end else begin
      mask_prev <= i_mask_flag;
      o_insn_done <= 1'b0;
      if (busy) begin
        if (count <= 4'h1) begin
          o_insn_done <= 1'b1;
          busy <= 1'b0;
        end else begin
          count <= count - 4'h1;
        end
      end else if (i_mask_flag && !mask_prev) begin
        busy <= 1'b1;
        count <= i_wait;
      end
    end
  end
endmodule : cpu_core_model

// [intc_core_test.sv]
// Self-checking testbench of the interrupt controller.
`timescale 1ns/100ps
`include "intc_params.svh"

module intc_core_test;
  import intc_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  bus_req_t bus = '0;
  pin_in_t pins = '{wakeup: 8'hff, ext_edge: 5'h1f};
  periph_req_t periph = '0;
  logic [3:0] cpu_wait = 4'h1;
  logic insn_done;
  logic [7:0] rdata;
  logic pend;
  logic [4:0] vec;
  logic [15:0] vaddr;
  logic mask;
  logic stk;
  logic hstart;
  int failures = 0;
  int tests_run = 0;
  logic [7:0] v;
  int n;

  always #5 i_clk_sys = ~i_clk_sys;

  intc_core dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_bus(bus), .i_pins(pins), .i_periph(periph),
    .i_insn_done(insn_done), .o_rdata(rdata), .o_irq_pending(pend), .o_vector(vec), .o_vector_addr(vaddr),
    .o_mask_flag(mask), .o_stacking(stk), .o_handler_start(hstart));

  cpu_core_model cpu (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_mask_flag(mask), .i_wait(cpu_wait),
    .o_insn_done(insn_done));

  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task chk_sig(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_sig

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    bus.wr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [7:0] got;
    rd(a, got);
    chk_reg(what, exp, got);
  endtask : rchk

  task timeout(input string what);
    failures++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    stop_test();
  endtask : timeout

  // Unmasks, waits for acceptance and follows the exception sequence to the first handler instruction.
  task take_irq(input logic [4:0] e);
    int t;
    int h;
    int s;
    t = -1;
    h = -1;
    s = 0;
    wr(`OFS_CPU_STATUS, 8'h00);
    // Let the unmask write settle so the stale mask of the write edge is not mistaken for acceptance.
    #1;
    for (n = 0; n < 20 && mask !== 1'b1; n++) begin
      @(posedge i_clk_sys);
      #1;
    end
    if (mask !== 1'b1)
      timeout("acceptance");
    chk_sig("vector", {11'h000, e}, {11'h000, vec});
    chk_sig("vector address", {10'h000, e, 1'b0}, vaddr);
    for (n = 0; n < 60 && h < 0; n++) begin
      @(posedge i_clk_sys);
      #1;
      if (insn_done === 1'b1) t = n;
      if (stk === 1'b1) s++;
      if (hstart === 1'b1) h = n;
    end
    if (h < 0)
      timeout("handler start");
    chk_sig("handler delay", 16'h000f, 16'(h - t));
    chk_sig("stacking cycles", 16'h0004, 16'(s));
  endtask : take_irq

  task end_test(input string what);
    $display("test %s finished, mismatches so far %0d", what, failures);
  endtask : end_test

  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    rchk(`OFS_FIRST_REQ, 8'h20, "first request");
    rchk(`OFS_SECOND_REQ, 8'h00, "second request");
    rchk(`OFS_WAKE_REQ, 8'h00, "wakeup request");
    rchk(`OFS_SECOND_EN, 8'h00, "second enable");
    wr(4'hf, 8'hff);
    rchk(4'hf, 8'h00, "unmapped");
    end_test("reset");

    wr(`OFS_CPU_STATUS, 8'h01);
    wr(`OFS_EXT_FN, 8'h1f);
    wr(`OFS_EDGE_POL, 8'h0a);
    @(posedge i_clk_sys);
    pins.ext_edge <= 5'h00;
    repeat (4) @(posedge i_clk_sys);
    rchk(`OFS_FIRST_REQ, 8'h35, "falling edges");
    pins.ext_edge <= 5'h1f;
    repeat (4) @(posedge i_clk_sys);
    rchk(`OFS_FIRST_REQ, 8'h3f, "rising edges");
    wr(`OFS_FIRST_REQ, 8'hfe);
    rchk(`OFS_FIRST_REQ, 8'h3e, "clear by zero");
    wr(`OFS_FIRST_EN, 8'h14);
    take_irq(5'h06);
    rchk(`OFS_FIRST_REQ, 8'h3e, "flags kept");
    chk_sig("mask after accept", 16'h0001, {15'h0000, mask});
    wr(`OFS_FIRST_REQ, 8'hfb);
    cpu_wait <= 4'hd;
    take_irq(5'h08);
    wr(`OFS_FIRST_REQ, 8'h00);
    rchk(`OFS_FIRST_REQ, 8'h20, "all cleared");
    end_test("edge pins");

    wr(`OFS_FIRST_EN, 8'h00);
    wr(`OFS_WAKE_FN, 8'hff);
    pins.wakeup <= 8'hf7;
    repeat (4) @(posedge i_clk_sys);
    rchk(`OFS_WAKE_REQ, 8'h08, "wakeup flag");
    wr(`OFS_CPU_STATUS, 8'h00);
    repeat (10) @(posedge i_clk_sys);
    #1;
    chk_sig("mask with group off", 16'h0000, {15'h0000, mask});
    chk_sig("pending with group off", 16'h0000, {15'h0000, pend});
    wr(`OFS_CPU_STATUS, 8'h01);
    wr(`OFS_FIRST_EN, 8'h20);
    cpu_wait <= 4'h3;
    take_irq(5'h09);
    wr(`OFS_WAKE_REQ, 8'h00);
    pins.wakeup <= 8'hff;
    end_test("wakeup");

    wr(`OFS_FIRST_EN, 8'h00);
    @(posedge i_clk_sys);
    periph.timer_a <= 1'b1;
    @(posedge i_clk_sys);
    periph.timer_a <= 1'b0;
    rchk(`OFS_FIRST_REQ, 8'ha0, "peripheral flag");
    wr(`OFS_FIRST_EN, 8'h80);
    take_irq(5'h0a);
    wr(`OFS_FIRST_EN, 8'h00);
    wr(`OFS_FIRST_REQ, 8'h00);
    end_test("peripheral");

    wr(`OFS_CMP_LO, 8'h05);
    wr(`OFS_CMP_HI, 8'h01);
    wr(`OFS_SECOND_EN, 8'h0c);
    wr(`OFS_TIMER_CTRL, 8'h02);
    v = 8'h00;
    for (n = 0; n < 600 && v[3:2] !== 2'b11; n++)
      rd(`OFS_SECOND_REQ, v);
    chk_reg("timer flags", 8'h0c, v & 8'h0c);
    wr(`OFS_SECOND_REQ, 8'hff);
    rchk(`OFS_SECOND_REQ, 8'h0c, "reserved bits");
    take_irq(5'h0d);
    end_test("timer");
    stop_test();
  end
endmodule : intc_core_test
